// ==== dacctl_pkg.sv ====
// Constants of the two-channel converter control block
package dacctl_pkg;
    // Register byte addresses
    localparam logic [31:0] ADDR_CTRL = 32'h400B_8000;
    localparam logic [31:0] ADDR_MODE = 32'h400B_8004;
    localparam logic [31:0] ADDR_CHEN = 32'h400B_8010;
    localparam logic [31:0] ADDR_CHDIS = 32'h400B_8014;
    localparam logic [31:0] ADDR_CHSTAT = 32'h400B_8018;
    localparam logic [31:0] ADDR_DATA = 32'h400B_8020;
    localparam logic [31:0] ADDR_IRQ_STAT = 32'h400B_8030;
    localparam logic [31:0] ADDR_IRQ_CLR = 32'h400B_8034;
    localparam logic [31:0] ADDR_IRQ_EN = 32'h400B_8038;
    localparam logic [31:0] ADDR_WPROT = 32'h400B_80E4;
    // Mode register layout
    localparam int MODE_TRIGGER_ENABLE = 0;
    localparam int MODE_TRIGGER_SOURCE_SELECT_LSB = 1;
    localparam int MODE_WORD = 4;
    localparam int MODE_ONE = 8;
    localparam int MODE_USEL_LSB = 16;
    localparam int MODE_TAG = 20;
    localparam int MODE_MAX_SPEED_MODE = 21;
    localparam int MODE_CONVERTER_CLOCK_DIVIDER = 22;
    localparam int MODE_STARTUP_LSB = 24;
    localparam logic [31:0] MODE_MASK = 32'h3F73_011F;
    localparam logic [31:0] MODE_RST = 32'h0000_0000;
    // Data item layout
    localparam int ITEM_TAG_LSB = 12;
    localparam int ITEM_HI_LSB = 16;
    // Trigger source codes
    localparam logic [2:0] TRG_EXT = 3'h0;
    localparam logic [2:0] TRG_LAST = 3'h5;
    // Interrupt status bits
    localparam int IRQ_TXRDY = 0;
    localparam int IRQ_EOC = 1;
    localparam int IRQ_WPV = 2;
    localparam int IRQ_W = 3;
    // Conversion timing: DAC clock periods per conversion
    localparam int CONV_DAC_PERIODS = 25;
    localparam int DIV_LO = 2;
    localparam int DIV_HI = 4;
    localparam logic [6:0] CONV_CYC_LO = 7'(CONV_DAC_PERIODS * DIV_LO);
    localparam logic [6:0] CONV_CYC_HI = 7'(CONV_DAC_PERIODS * DIV_HI);
    // Startup delay table in peripheral clock periods
    localparam logic [11:0] SU_STEP_LO = 12'h008;
    localparam logic [11:0] SU_BASE_MID = 12'h040;
    localparam logic [11:0] SU_STEP_MID = 12'h010;
    localparam logic [11:0] SU_BASE_HI = 12'h200;
    localparam logic [11:0] SU_STEP_HI = 12'h040;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01
    } dacctl_state_t;
endpackage

// ==== dacctl_top.sv ====
// Two-channel converter control: AHB-Lite registers, triggers, sequencing
//
// Summary of operation
// - Trigger code 0 external, 1-3 timer channels, 4-5 PWM lines, 6-7 reserved.
// - User channel select value 0 picks channel 0, value 1 channel 1.
// - Tag bit 0 routes to user-selected channel; tag bit 1 uses tags.
// - Maximum speed bit 0 gives normal timing, 1 gives maximum speed.
// - Converter clock is peripheral clock divided by 2 (code 0) or 4.
// - Startup code maps to 0..112 periods, then 512 plus 64 per step.
// - A one in channel enable bit 0 or 1 enables that channel.
// - A one in channel disable bit 0 or 1 disables that channel.
// - Channel status bits 0 and 1 show which channels are enabled.
// - Enable and disable writes are ignored while write protect is set.
// - Trigger mode starts on selected rising edge; else converts at once.
// - Word mode pushes lower half-word first, then upper half-word.
// - Tag mode takes channel from bits 13:12, and 29:28 for second.
// - Maximum speed times conversions by counter, not end-of-cycle.
module dacctl_top #(
    parameter int DATA_W = 12
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic TRIG_EXT,
    input wire logic [2:0] TRIG_TIO,
    input wire logic [1:0] TRIG_PWM,
    input wire logic CORE_EOC,
    output logic DAC_CLK,
    output logic DAC_START,
    output logic [DATA_W-1:0] DAC_DATA,
    output logic DAC_CHAN,
    output logic [1:0] DAC_CH_EN,
    output logic IRQ
);
    logic swrst_r, swrst_nxt;
    logic srst;
    assign srst = RST | swrst_r;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: trigger lines and core end-of-cycle
    logic [6:0] sy1_r, sy1_nxt, sy2_r, sy2_nxt, sy3_r, sy3_nxt;
    logic [6:0] edg;
    logic trg_edge, eoc_edge;

    always_comb begin
        sy1_nxt = {CORE_EOC, TRIG_PWM, TRIG_TIO, TRIG_EXT};
        sy2_nxt = sy1_r;
        sy3_nxt = sy2_r;
    end

    always_ff @(posedge CLK) begin
        if (srst) begin
            sy1_r <= 7'h00;
            sy2_r <= 7'h00;
            sy3_r <= 7'h00;
        end else begin
            sy1_r <= sy1_nxt;
            sy2_r <= sy2_nxt;
            sy3_r <= sy3_nxt;
        end
    end

    assign edg = sy2_r & ~sy3_r;
    assign eoc_edge = edg[6];

    ////////////////////////////////////////////////////////////////////////
    // Register file on AHB-Lite, zero wait states
    logic dp_wr_r, dp_wr_nxt;
    logic [31:0] dp_addr_r, dp_addr_nxt, hrdata_r, hrdata_nxt;
    logic [31:0] mode_r, mode_nxt;
    logic [1:0] chen_r, chen_nxt;
    logic write_protect_enable_r, write_protect_enable_nxt, irq_r, irq_nxt;
    localparam int IRQ_W = dacctl_pkg::IRQ_W;
    logic [IRQ_W-1:0] ien_r, ien_nxt, ist_r, ist_nxt, evt;
    logic ap, wr, wp_hit, eoc_evt, txrdy, txrdy_d_r;
    logic trigger_enable, word, tag, max_speed_mode, converter_clock_divider;
    logic [2:0] trigger_source_select;
    logic [1:0] usel;
    logic [5:0] startup;

    assign trigger_enable = mode_r[dacctl_pkg::MODE_TRIGGER_ENABLE];
    assign trigger_source_select = mode_r[dacctl_pkg::MODE_TRIGGER_SOURCE_SELECT_LSB +: 3];
    assign word = mode_r[dacctl_pkg::MODE_WORD];
    assign usel = mode_r[dacctl_pkg::MODE_USEL_LSB +: 2];
    assign tag = mode_r[dacctl_pkg::MODE_TAG];
    assign max_speed_mode = mode_r[dacctl_pkg::MODE_MAX_SPEED_MODE];
    assign converter_clock_divider = mode_r[dacctl_pkg::MODE_CONVERTER_CLOCK_DIVIDER];
    assign startup = mode_r[dacctl_pkg::MODE_STARTUP_LSB +: 6];

    // Reserved codes pick no source, so trigger mode never starts
    always_comb begin
        if (trigger_source_select <= dacctl_pkg::TRG_LAST)
            trg_edge = edg[trigger_source_select];
        else
            trg_edge = 1'b0;
    end

    assign ap = HSEL && HTRANS[1] && HREADY;
    assign wr = dp_wr_r && HREADY;
    assign wp_hit = wr && write_protect_enable_r && (dp_addr_r == dacctl_pkg::ADDR_MODE ||
        dp_addr_r == dacctl_pkg::ADDR_CHEN ||
        dp_addr_r == dacctl_pkg::ADDR_CHDIS);
    assign evt = {wp_hit, eoc_evt, txrdy & ~txrdy_d_r};

    always_comb begin
        dp_wr_nxt = ap && HWRITE;
        dp_addr_nxt = ap ? HADDR : dp_addr_r;
        hrdata_nxt = hrdata_r;
        mode_nxt = mode_r;
        chen_nxt = chen_r;
        write_protect_enable_nxt = write_protect_enable_r;
        ien_nxt = ien_r;
        ist_nxt = ist_r;
        swrst_nxt = 1'b0;
        // Read data is fetched in the address phase so HRDATA is a flop
        if (ap && !HWRITE) begin
            case (HADDR)
                dacctl_pkg::ADDR_MODE: hrdata_nxt = mode_r;
                dacctl_pkg::ADDR_CHSTAT: hrdata_nxt = {30'h0, chen_r};
                dacctl_pkg::ADDR_IRQ_STAT: hrdata_nxt = 32'(ist_r);
                dacctl_pkg::ADDR_IRQ_EN: hrdata_nxt = 32'(ien_r);
                dacctl_pkg::ADDR_WPROT: hrdata_nxt = {31'h0, write_protect_enable_r};
                default: hrdata_nxt = 32'h0000_0000;
            endcase
        end
        if (wr && !write_protect_enable_r) begin
            case (dp_addr_r)
                dacctl_pkg::ADDR_MODE: mode_nxt = HWDATA & dacctl_pkg::MODE_MASK;
                dacctl_pkg::ADDR_CHEN: chen_nxt = chen_r | HWDATA[1:0];
                dacctl_pkg::ADDR_CHDIS: chen_nxt = chen_r & ~HWDATA[1:0];
                default: chen_nxt = chen_r;
            endcase
        end
        if (wr && dp_addr_r == dacctl_pkg::ADDR_WPROT)
            write_protect_enable_nxt = HWDATA[0];
        if (wr && dp_addr_r == dacctl_pkg::ADDR_IRQ_EN)
            ien_nxt = HWDATA[IRQ_W-1:0];
        if (wr && dp_addr_r == dacctl_pkg::ADDR_IRQ_CLR)
            ist_nxt = ist_r & ~HWDATA[IRQ_W-1:0];
        // A new event beats a clear in the same cycle
        ist_nxt = ist_nxt | evt;
        irq_nxt = |(ist_nxt & ien_nxt);
        if (wr && dp_addr_r == dacctl_pkg::ADDR_CTRL)
            swrst_nxt = HWDATA[0];
    end

    always_ff @(posedge CLK) begin
        // The bus pipeline survives a software reset so the bus stays sane
        if (RST) begin
            dp_wr_r <= 1'b0;
            dp_addr_r <= 32'h0000_0000;
            hrdata_r <= 32'h0000_0000;
            swrst_r <= 1'b0;
        end else begin
            dp_wr_r <= dp_wr_nxt;
            dp_addr_r <= dp_addr_nxt;
            hrdata_r <= hrdata_nxt;
            swrst_r <= swrst_nxt;
        end
        if (srst) begin
            mode_r <= dacctl_pkg::MODE_RST;
            chen_r <= 2'h0;
            write_protect_enable_r <= 1'b0;
            ien_r <= '0;
            ist_r <= '0;
            irq_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            chen_r <= chen_nxt;
            write_protect_enable_r <= write_protect_enable_nxt;
            ien_r <= ien_nxt;
            ist_r <= ist_nxt;
            irq_r <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion engine
    dacctl_pkg::dacctl_state_t state_r, state_nxt;
    logic [1:0] pend_cnt_r, pend_cnt_nxt, sel_ch;
    logic [15:0] pend0_r, pend0_nxt, pend1_r, pend1_nxt;
    logic [11:0] su_cnt_r, su_cnt_nxt;
    logic [6:0] cv_cnt_r, cv_cnt_nxt, conv_cyc;
    logic div_r, div_nxt, dclk_r, dclk_nxt, start_r, start_nxt;
    logic [DATA_W-1:0] data_r, data_nxt;
    logic chan_r, chan_nxt;
    logic [1:0] chen_d_r;
    logic go, wr_data, ch_rise;

    function automatic logic [11:0] su_delay(input logic [5:0] c);
        if (c < 6'h04)
            return 12'(c) * dacctl_pkg::SU_STEP_LO;
        else if (c < 6'h08)
            return dacctl_pkg::SU_BASE_MID +
                (12'(c) - 12'h004) * dacctl_pkg::SU_STEP_MID;
        else
            return dacctl_pkg::SU_BASE_HI +
                (12'(c) - 12'h008) * dacctl_pkg::SU_STEP_HI;
    endfunction

    assign txrdy = pend_cnt_r == 2'h0;
    assign ch_rise = |(chen_r & ~chen_d_r);
    assign wr_data = wr && dp_addr_r == dacctl_pkg::ADDR_DATA;
    assign conv_cyc = converter_clock_divider ? dacctl_pkg::CONV_CYC_HI : dacctl_pkg::CONV_CYC_LO;
    assign go = trigger_enable ? trg_edge : 1'b1;
    assign sel_ch = tag ? pend0_r[dacctl_pkg::ITEM_TAG_LSB +: 2] : usel;

    always_comb begin
        state_nxt = state_r;
        pend_cnt_nxt = pend_cnt_r;
        pend0_nxt = pend0_r;
        pend1_nxt = pend1_r;
        cv_cnt_nxt = cv_cnt_r;
        data_nxt = data_r;
        chan_nxt = chan_r;
        start_nxt = 1'b0;
        eoc_evt = 1'b0;
        // Divide by 2 toggles every cycle, by 4 every other cycle
        div_nxt = ~div_r;
        dclk_nxt = (!converter_clock_divider || div_r) ? ~dclk_r : dclk_r;
        // Any channel going live restarts the startup wait
        if (ch_rise)
            su_cnt_nxt = su_delay(startup);
        else if (su_cnt_r != 12'h000)
            su_cnt_nxt = su_cnt_r - 12'h001;
        else
            su_cnt_nxt = su_cnt_r;
        // Writes while not ready are dropped rather than corrupting items
        if (wr_data && txrdy) begin
            pend0_nxt = HWDATA[15:0];
            pend1_nxt = HWDATA[dacctl_pkg::ITEM_HI_LSB +: 16];
            pend_cnt_nxt = word ? 2'h2 : 2'h1;
        end
        case (state_r)
            dacctl_pkg::ST_IDLE: begin
                // The wait is loaded one cycle after the enable lands
                if (pend_cnt_r != 2'h0 && su_cnt_r == 12'h000 && !ch_rise &&
                    |chen_r && go) begin
                    pend0_nxt = pend1_r;
                    pend_cnt_nxt = pend_cnt_r - 2'h1;
                    // Items tagged for an absent or disabled channel drop
                    if (!sel_ch[1] && chen_r[sel_ch[0]]) begin
                        start_nxt = 1'b1;
                        data_nxt = pend0_r[DATA_W-1:0];
                        chan_nxt = sel_ch[0];
                        cv_cnt_nxt = conv_cyc;
                        state_nxt = dacctl_pkg::ST_CONV;
                    end
                end
            end
            dacctl_pkg::ST_CONV: begin
                if (cv_cnt_r != 7'h00)
                    cv_cnt_nxt = cv_cnt_r - 7'h01;
                // Counter saves the two cycles the synchroniser costs
                if (max_speed_mode ? cv_cnt_r == 7'h01 : eoc_edge) begin
                    eoc_evt = 1'b1;
                    state_nxt = dacctl_pkg::ST_IDLE;
                end
            end
            default: state_nxt = dacctl_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (srst) begin
            state_r <= dacctl_pkg::ST_IDLE;
            pend_cnt_r <= 2'h0;
            pend0_r <= 16'h0000;
            pend1_r <= 16'h0000;
            su_cnt_r <= 12'h000;
            cv_cnt_r <= 7'h00;
            div_r <= 1'b0;
            dclk_r <= 1'b0;
            start_r <= 1'b0;
            data_r <= '0;
            chan_r <= 1'b0;
            chen_d_r <= 2'h0;
            txrdy_d_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            pend_cnt_r <= pend_cnt_nxt;
            pend0_r <= pend0_nxt;
            pend1_r <= pend1_nxt;
            su_cnt_r <= su_cnt_nxt;
            cv_cnt_r <= cv_cnt_nxt;
            div_r <= div_nxt;
            dclk_r <= dclk_nxt;
            start_r <= start_nxt;
            data_r <= data_nxt;
            chan_r <= chan_nxt;
            chen_d_r <= chen_r;
            txrdy_d_r <= txrdy;
        end
    end

    assign HRDATA = hrdata_r;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign DAC_CLK = dclk_r;
    assign DAC_START = start_r;
    assign DAC_DATA = data_r;
    assign DAC_CHAN = chan_r;
    assign DAC_CH_EN = chen_r;
    assign IRQ = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [6:0] age_r;
    always_ff @(posedge CLK) begin
        if (srst || state_r != dacctl_pkg::ST_CONV)
            age_r <= 7'h00;
        else
            age_r <= age_r + 7'h01;
    end

    default clocking dck @(posedge CLK); endclocking
    default disable iff (srst);

    trg_reserved_a: assert property (trigger_enable && trigger_source_select > 3'h5 |=> !start_r)
        else $error("start with reserved trigger code");
    trg_wait_a: assert property (trigger_enable && !trg_edge |=> !start_r)
        else $error("trigger mode started without edge");
    ch_enable_a: assert property (wr && dp_addr_r == dacctl_pkg::ADDR_CHEN &&
        !write_protect_enable_r |=> (chen_r & $past(HWDATA[1:0])) == $past(HWDATA[1:0]))
        else $error("channel not enabled");
    ch_disable_a: assert property (wr && dp_addr_r == dacctl_pkg::ADDR_CHDIS &&
        !write_protect_enable_r |=> (chen_r & $past(HWDATA[1:0])) == 2'h0)
        else $error("channel not disabled");
    wp_block_a: assert property (wr && write_protect_enable_r && dp_addr_r != dacctl_pkg::ADDR_CTRL
        |=> chen_r == $past(chen_r))
        else $error("protected write changed channels");
    ch_status_a: assert property (ap && !HWRITE &&
        HADDR == dacctl_pkg::ADDR_CHSTAT |=> HRDATA == {30'h0, $past(chen_r)})
        else $error("channel status readback wrong");
    user_chan_a: assert property (state_r == dacctl_pkg::ST_IDLE && !tag &&
        start_nxt |=> DAC_CHAN == $past(usel[0]))
        else $error("wrong user channel");
    max_speed_mode_len_a: assert property (state_r == dacctl_pkg::ST_CONV && max_speed_mode &&
        state_nxt == dacctl_pkg::ST_IDLE |-> age_r == conv_cyc - 7'h01)
        else $error("max speed conversion length wrong");
    div2_clk_a: assert property (!converter_clock_divider ##1 !converter_clock_divider |-> DAC_CLK != $past(DAC_CLK))
        else $error("divide by 2 clock not toggling");
    su_load_a: assert property (ch_rise && startup == 6'h07
        |=> su_cnt_r == 12'h070 && !start_r)
        else $error("startup delay load wrong");
    word_push_a: assert property (wr_data && txrdy && word |=>
        pend_cnt_r == 2'h2 && pend0_r == $past(HWDATA[15:0]))
        else $error("word write not split");

    conv_max_speed_mode_c: cover property (start_r && max_speed_mode);
    tag_ch1_c: cover property (start_r && tag && DAC_CHAN);
    trig_conv_c: cover property (trigger_enable && start_r ##[1:200] eoc_evt);
endmodule

// ==== dacctl_far_side.sv ====
// Far-side model: analog core end-of-cycle signal and trigger sources
module dacctl_far_side (
    input wire logic clk,
    input wire logic dac_start,
    input wire logic dac_clk,
    input wire logic trig_go,
    input wire logic [2:0] trig_code,
    output logic trig_ext,
    output logic [2:0] trig_tio,
    output logic [1:0] trig_pwm,
    output logic core_eoc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] line_r = 6'h00;
    logic busy_r = 1'b0;
    logic dclk_q = 1'b0;
    int cnt = 0;
    assign trig_ext = line_r[0];
    assign trig_tio = line_r[3:1];
    assign trig_pwm = line_r[5:4];
    initial core_eoc = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // Code 0 external, 1-3 timer lines, 4-5 PWM lines; above 5 fires all
    always @(posedge clk) begin
        if (!trig_go) begin
            line_r <= 6'h00;
        end else if (trig_code > 3'h5) begin
            line_r <= 6'h3F;
        end else begin
            line_r <= 6'h01 << trig_code;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Core settles after 25 converter clock periods, then flags end of cycle
    always @(posedge clk) begin
        dclk_q <= dac_clk;
        core_eoc <= 1'b0;
        if (dac_start) begin
            busy_r <= 1'b1;
            cnt <= 0;
        end else if (busy_r && dac_clk && !dclk_q) begin
            cnt <= cnt + 1;
            if (cnt == 24) begin
                busy_r <= 1'b0;
                core_eoc <= 1'b1;
            end
        end
    end
endmodule

// ==== test_dac_converter_control.sv ====
// Self-checking testbench of the converter control block
module test_dac_converter_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ONE = 32'h1 << dacctl_pkg::MODE_ONE;
    localparam logic [31:0] MAX_SPEED_MODE = 32'h1 << dacctl_pkg::MODE_MAX_SPEED_MODE;
    localparam logic [31:0] WORD = 32'h1 << dacctl_pkg::MODE_WORD;
    localparam logic [31:0] TAG = 32'h1 << dacctl_pkg::MODE_TAG;
    localparam logic [31:0] TRIGGER_ENABLE = 32'h1 << dacctl_pkg::MODE_TRIGGER_ENABLE;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic HSEL = 1'b0;
    logic HWRITE = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [31:0] HWDATA = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HRDATA;
    logic HREADYOUT, HRESP, TRIG_EXT, CORE_EOC, DAC_CLK, DAC_START;
    logic DAC_CHAN, IRQ;
    logic [2:0] TRIG_TIO;
    logic [1:0] TRIG_PWM, DAC_CH_EN;
    logic [11:0] DAC_DATA;
    logic trig_go = 1'b0;
    logic [2:0] trig_code = 3'h0;
    logic [31:0] rd;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    always #5 CLK = ~CLK;
    dacctl_top #(.DATA_W(12)) DUT (.CLK(CLK), .RST(RST), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TRIG_EXT(TRIG_EXT),
        .TRIG_TIO(TRIG_TIO), .TRIG_PWM(TRIG_PWM), .CORE_EOC(CORE_EOC),
        .DAC_CLK(DAC_CLK), .DAC_START(DAC_START), .DAC_DATA(DAC_DATA),
        .DAC_CHAN(DAC_CHAN), .DAC_CH_EN(DAC_CH_EN), .IRQ(IRQ));
    dacctl_far_side far (.clk(CLK), .dac_start(DAC_START),
        .dac_clk(DAC_CLK), .trig_go(trig_go), .trig_code(trig_code),
        .trig_ext(TRIG_EXT), .trig_tio(TRIG_TIO), .trig_pwm(TRIG_PWM),
        .core_eoc(CORE_EOC));
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Whole run needs some 2000 cycles; far more means a hang
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            test_done;
        end
    end
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One single AHB-Lite transfer; read data taken at the data phase end
    task automatic bus(logic wr, logic [31:0] a, logic [31:0] d);
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= wr;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wr ? d : 32'h0;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask
    task automatic wait_start(int lim);
        n = 0;
        do begin
            @(negedge CLK);
            n++;
        end while (DAC_START !== 1'b1 && n < lim);
    endtask
    task automatic idle(int c);
        repeat (c) @(negedge CLK);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        bus(0, dacctl_pkg::ADDR_MODE, 0);
        check("mode reset", 32'h0, rd);
        check("resp", 32'h2, 32'({HREADYOUT, HRESP}));
        bus(0, dacctl_pkg::ADDR_CHSTAT, 0);
        check("status reset", 32'h0, rd);
        bus(0, 32'h400B_8008, 0);
        check("unmapped", 32'h0, rd);
        bus(1, dacctl_pkg::ADDR_MODE, 32'hFFFF_FFFF);
        bus(0, dacctl_pkg::ADDR_MODE, 0);
        check("mode mask", dacctl_pkg::MODE_MASK, rd);
        // Software reset; the task's own idle cycle covers the reset cycle
        bus(1, dacctl_pkg::ADDR_CTRL, 32'h1);
        bus(0, dacctl_pkg::ADDR_MODE, 0);
        check("soft reset", 32'h0, rd);
    endtask
    task automatic t_chan;
        logic [31:0] a[6] = '{dacctl_pkg::ADDR_CHEN, dacctl_pkg::ADDR_CHEN,
            dacctl_pkg::ADDR_CHEN, dacctl_pkg::ADDR_CHDIS,
            dacctl_pkg::ADDR_CHDIS, dacctl_pkg::ADDR_CHDIS};
        logic [31:0] d[6] = '{32'h1, 32'h0, 32'hFFFF_FFFE, 32'h0, 32'h1, 32'h2};
        logic [1:0] e[6] = '{2'h1, 2'h1, 2'h3, 2'h3, 2'h2, 2'h0};
        bus(1, dacctl_pkg::ADDR_MODE, ONE | MAX_SPEED_MODE);
        for (int i = 0; i < 6; i++) begin
            bus(1, a[i], d[i]);
            bus(0, dacctl_pkg::ADDR_CHSTAT, 0);
            check("status", 32'(e[i]), rd);
            check("pins", 32'(e[i]), 32'(DAC_CH_EN));
        end
    endtask
    task automatic t_wprot;
        bus(1, dacctl_pkg::ADDR_WPROT, 32'h1);
        bus(1, dacctl_pkg::ADDR_CHEN, 32'h3);
        bus(0, dacctl_pkg::ADDR_CHSTAT, 0);
        check("locked", 32'h0, rd);
        bus(0, dacctl_pkg::ADDR_IRQ_STAT, 0);
        check("violation", 32'h1, 32'(rd[dacctl_pkg::IRQ_WPV]));
        bus(1, dacctl_pkg::ADDR_WPROT, 32'h0);
        bus(1, dacctl_pkg::ADDR_CHEN, 32'h2);
        bus(0, dacctl_pkg::ADDR_CHSTAT, 0);
        check("unlocked", 32'h2, rd);
        bus(1, dacctl_pkg::ADDR_CHDIS, 32'h2);
        bus(1, dacctl_pkg::ADDR_IRQ_CLR, 32'h4);
    endtask
    // Tag bits set in the item must be ignored while tag mode is off
    task automatic t_user;
        bus(1, dacctl_pkg::ADDR_IRQ_EN, 32'h2);
        bus(1, dacctl_pkg::ADDR_CHEN, 32'h3);
        for (int s = 0; s < 3; s++) begin
            bus(1, dacctl_pkg::ADDR_MODE, ONE | MAX_SPEED_MODE | (s << 16));
            bus(1, dacctl_pkg::ADDR_DATA, 32'h0000_35A0 + s);
            wait_start(20);
            check("started", 32'(s < 2), 32'(DAC_START));
            if (s < 2) begin
                check("data", 32'h5A0 + s, 32'(DAC_DATA));
                check("chan", s, 32'(DAC_CHAN));
                idle(60);
                check("irq on", 32'h1, 32'(IRQ));
                bus(1, dacctl_pkg::ADDR_IRQ_CLR, 32'h2);
                idle(3);
                check("irq off", 32'h0, 32'(IRQ));
            end
        end
        bus(1, dacctl_pkg::ADDR_IRQ_EN, 32'h0);
    endtask
    task automatic t_word_tag;
        bus(1, dacctl_pkg::ADDR_MODE, ONE | WORD | TAG);
        bus(1, dacctl_pkg::ADDR_DATA, 32'h1ABC_0456);
        wait_start(20);
        check("lo data", 32'h456, 32'(DAC_DATA));
        check("lo chan", 32'h0, 32'(DAC_CHAN));
        wait_start(200);
        check("hi data", 32'hABC, 32'(DAC_DATA));
        check("hi chan", 32'h1, 32'(DAC_CHAN));
        idle(150);
    endtask
    task automatic t_speed;
        int len;
        for (int dv = 0; dv < 2; dv++) begin
            len = dv ? 100 : 50;
            bus(1, dacctl_pkg::ADDR_MODE, ONE | MAX_SPEED_MODE | WORD | (dv << 22));
            idle(8);
            @(posedge DAC_CLK);
            wait (DAC_CLK === 1'b0);
            n = 0;
            do begin
                @(negedge CLK);
                n++;
            end while (DAC_CLK !== 1'b1 && n < 9);
            // The loop also counts the cycle in which the clock rises
            check("half period", dv ? 32'h2 : 32'h1, n - 1);
            bus(1, dacctl_pkg::ADDR_DATA, 32'h0222_0111);
            wait_start(20);
            wait_start(300);
            check("spacing", 1, (n >= len && n <= len + 4));
            idle(len + 10);
        end
    endtask
    task automatic t_trig;
        for (int c = 0; c < 7; c++) begin
            bus(1, dacctl_pkg::ADDR_MODE, ONE | MAX_SPEED_MODE | TRIGGER_ENABLE | (c << 1));
            bus(1, dacctl_pkg::ADDR_DATA, 32'h0000_0300 + c);
            wait_start(10);
            check("held", 32'h0, 32'(DAC_START));
            @(posedge CLK);
            trig_code <= 3'(c);
            trig_go <= 1'b1;
            repeat (4) @(posedge CLK);
            trig_go <= 1'b0;
            wait_start(20);
            check("trig", 32'(c < 6), 32'(DAC_START));
            idle(60);
        end
        bus(1, dacctl_pkg::ADDR_MODE, ONE | MAX_SPEED_MODE);
        wait_start(20);
        check("free run", 32'h306, 32'(DAC_DATA));
        idle(60);
        bus(1, dacctl_pkg::ADDR_CHDIS, 32'h3);
    endtask
    task automatic t_startup;
        int code[4] = '{0, 1, 4, 7};
        int dl[4] = '{0, 8, 64, 112};
        for (int i = 0; i < 4; i++) begin
            bus(1, dacctl_pkg::ADDR_MODE, ONE | MAX_SPEED_MODE | (code[i] << 24));
            bus(1, dacctl_pkg::ADDR_DATA, 32'h0000_0700 + i);
            bus(1, dacctl_pkg::ADDR_CHEN, 32'h1);
            wait_start(dl[i] + 20);
            check("start", 32'h1, 32'(DAC_START));
            check("delay", 1, (n >= dl[i] && n <= dl[i] + 6));
            idle(60);
            bus(1, dacctl_pkg::ADDR_CHDIS, 32'h1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        t_regs;
        t_chan;
        t_wprot;
        t_user;
        t_word_tag;
        t_speed;
        t_trig;
        t_startup;
        test_done;
    end
endmodule
